//--- design/fplbc_ctrl.sv
// Front panel indicator and push-button controller with an AHB-Lite register slave
//
// Summary of operation
// - Every blinking indication toggles near one hertz with equal on and off.
// - Any amber status forces the green status element off.
// - During controller initialization, status alternates green and amber at blink rate.
// - Status is steady green when running, blinking green when degraded.
// - Steady amber critical, blinking amber non-critical, dark during stop.
// - Power indicator steady in S0, blinks in S1, off in off, S4, S5.
// - Power indicator blinks slowly across S3 through S1.
// - Without power management, power indicator follows system power, except that after an abrupt power-down it stays off until firmware clears.
// - Sleep indication kept on standby, restored after abrupt power-down until firmware clears.
// - Disk indicator flashes on activity, off when idle, off, S4, S5 or S1.
// - Identify indicator lit while identify is active by command or button.
// - Identify press toggles front and rear identify indicators together.
// - Power press requests power toggle, or sleep when sleep button enabled.
// - Reset press requests a system reboot.
// - Diagnostic press requests halt and a non-maskable interrupt.
// - Power button ignored until controller initialization completes.
`timescale 1ns/10ps

`include "fplbc_map.svh"

module fplbc_ctrl
  import fplbc_pkg::*;
#(
  parameter int BLINK_HALF_CYC = `FPLBC_BLINK_HALF,
  parameter int DEB_CYC        = `FPLBC_DEB_CYC,
  parameter int DISK_CYC       = `FPLBC_DISK_CYC
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Panel pins, buttons active low
  input  wire logic        pwrBtn_n,
  input  wire logic        idBtn_n,
  input  wire logic        rstBtn_n,
  input  wire logic        nmiBtn_n,
  input  wire logic        dcPowerOn,
  input  wire logic        diskActivity,
  // Indicators
  output logic             powerLed,
  output logic             statusGreenLed,
  output logic             statusAmberLed,
  output logic             diskLed,
  output logic             idFrontLed,
  output logic             idRearLed,
  // Requests to the platform
  output logic             powerToggleReq,
  output logic             sleepReq,
  output logic             resetReq,
  output logic             haltReq,
  output logic             nmiReq
);

  // ==========================================================
  // Register decode helper
  function automatic logic [1:0] regIndex(input logic [31:0] addr);
    regIndex = addr[3:2];
  endfunction

  function automatic logic regHit(input logic [31:0] addr);
    regHit = (addr[31:4] == 28'h0000000);
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [5:0] pinMeta_r;
  logic [5:0] pinSync_r;
  logic [5:0] pinRaw;

  assign pinRaw = {diskActivity, dcPowerOn, ~nmiBtn_n, ~rstBtn_n, ~idBtn_n, ~pwrBtn_n};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinMeta_r <= 6'h00;
      pinSync_r <= 6'h00;
    end
    else if (clkEn)
    begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  logic dcPwr;
  logic diskAct;

  assign dcPwr   = pinSync_r[4];
  assign diskAct = pinSync_r[5];

  // ==========================================================
  // Button debounce, one filter per button
  logic [3:0] btnStable_r;
  logic [3:0] btnPress_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : gDeb
      logic [31:0] debCnt_r;

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          debCnt_r        <= 32'h00000000;
          btnStable_r[gi] <= 1'b0;
          btnPress_r[gi]  <= 1'b0;
        end
        else if (clkEn)
        begin
          btnPress_r[gi] <= 1'b0;
          if (pinSync_r[gi] == btnStable_r[gi])
            debCnt_r <= 32'h00000000;
          else if (debCnt_r == 32'(DEB_CYC - 1))
          begin
            debCnt_r        <= 32'h00000000;
            btnStable_r[gi] <= pinSync_r[gi];
            btnPress_r[gi]  <= pinSync_r[gi];
          end
          else
            debCnt_r <= debCnt_r + 32'h00000001;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Shared blink generator
  logic [31:0] blinkCnt_r;
  logic        blink_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      blinkCnt_r <= 32'h00000000;
      blink_r    <= 1'b0;
    end
    else if (clkEn)
    begin
      if (blinkCnt_r == 32'(BLINK_HALF_CYC - 1))
      begin
        blinkCnt_r <= 32'h00000000;
        blink_r    <= ~blink_r;
      end
      else
        blinkCnt_r <= blinkCnt_r + 32'h00000001;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  logic [`FPLBC_CTRL_WIDTH-1:0] ctrl_r;
  logic                         wrPend_r;
  logic [1:0]                   wrIdx_r;
  logic                         wrHit_r;
  logic [31:0]                  hrdata_r;
  logic [31:0]                  statusWord;
  logic                         addrPhase;

  // Frozen clock enable stalls the bus rather than losing a transfer
  assign hreadyout = clkEn;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign addrPhase = hsel & htrans[1] & hready & clkEn;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrPend_r <= 1'b0;
      wrIdx_r  <= 2'h0;
      wrHit_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      wrPend_r <= addrPhase & hwrite;
      wrIdx_r  <= regIndex(haddr);
      wrHit_r  <= regHit(haddr);
    end
  end

  logic wrCtrl;
  logic wrIdent;
  logic wrFwClr;

  assign wrCtrl  = clkEn & wrPend_r & wrHit_r & (wrIdx_r == regIndex(32'(`FPLBC_OFS_CTRL)));
  assign wrIdent = clkEn & wrPend_r & wrHit_r & (wrIdx_r == regIndex(32'(`FPLBC_OFS_IDENT)));
  assign wrFwClr = clkEn & wrPend_r & wrHit_r & (wrIdx_r == regIndex(32'(`FPLBC_OFS_FWCLR)))
                   & hwdata[0];

  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_r <= `FPLBC_CTRL_RESET;
    else if (wrCtrl)
      ctrl_r <= hwdata[`FPLBC_CTRL_WIDTH-1:0];
  end

  // ==========================================================
  // Control fields
  logic [2:0] sleepState;
  logic       acpiMode;
  fplbc_sev_t severity;
  logic       initDone;
  logic       sleepBtnEn;
  logic       orderlyOff;

  assign sleepState = ctrl_r[`FPLBC_CTRL_SLP_MSB:`FPLBC_CTRL_SLP_LSB];
  assign acpiMode   = ctrl_r[`FPLBC_CTRL_ACPI];
  assign severity   = fplbc_sev_t'(ctrl_r[`FPLBC_CTRL_SEV_MSB:`FPLBC_CTRL_SEV_LSB]);
  assign initDone   = ctrl_r[`FPLBC_CTRL_INITDN];
  assign sleepBtnEn = ctrl_r[`FPLBC_CTRL_SLPBTN];
  assign orderlyOff = ctrl_r[`FPLBC_CTRL_ORDOFF];

  // ==========================================================
  // Identify state, shared by front and rear indicators
  logic idOn_r;

  always_ff @(posedge clk)
  begin
    if (srst)
      idOn_r <= 1'b0;
    else if (clkEn)
    begin
      // A press in the same cycle as a command write wins
      if (btnPress_r[FPLBC_BTN_ID])
        idOn_r <= ~idOn_r;
      else if (wrIdent)
        idOn_r <= hwdata[0];
    end
  end

  // ==========================================================
  // Power indicator mode from the power state
  fplbc_plmode_t plLive;

  always_comb
  begin
    plLive = FPLBC_PL_OFF;
    if (!acpiMode)
      plLive = dcPwr ? FPLBC_PL_ON : FPLBC_PL_OFF;
    else
    begin
      unique case (sleepState)
        3'h0:    plLive = FPLBC_PL_ON;
        3'h1,
        3'h2,
        3'h3:    plLive = FPLBC_PL_BLINK;
        default: plLive = FPLBC_PL_OFF;
      endcase
    end
  end

  // ==========================================================
  // Sleep indication held across an abrupt power-down
  fplbc_plmode_t plSaved_r;
  logic          restore_r;
  logic          dcPwrPrev_r;
  logic          dcFall;

  assign dcFall = dcPwrPrev_r & ~dcPwr;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dcPwrPrev_r <= 1'b0;
      plSaved_r   <= FPLBC_PL_OFF;
      restore_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      dcPwrPrev_r <= dcPwr;
      if (dcFall && !orderlyOff && !restore_r)
      begin
        plSaved_r <= plLive;
        restore_r <= 1'b1;
      end
      else if (wrFwClr && dcPwr)
        restore_r <= 1'b0;
    end
  end

  fplbc_plmode_t plShown;

  always_comb
  begin
    plShown = plLive;
    if (restore_r)
      plShown = dcPwr ? plSaved_r : FPLBC_PL_OFF;
  end

  // ==========================================================
  // System status colours
  logic greenNxt;
  logic amberNxt;

  always_comb
  begin
    greenNxt = 1'b0;
    amberNxt = 1'b0;
    if (!initDone)
    begin
      greenNxt = blink_r;
      amberNxt = ~blink_r;
    end
    else
    begin
      unique case (severity)
        FPLBC_SEV_OK:       greenNxt = 1'b1;
        FPLBC_SEV_DEGRADED: greenNxt = blink_r;
        FPLBC_SEV_NONCRIT:  amberNxt = blink_r;
        FPLBC_SEV_CRIT:     amberNxt = 1'b1;
        default:            amberNxt = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Disk activity stretch, so short bursts stay visible
  logic [31:0] diskCnt_r;
  logic        diskOff;

  assign diskOff = ~dcPwr | (acpiMode & ((sleepState == 3'h1) | (sleepState >= 3'h4)));

  always_ff @(posedge clk)
  begin
    if (srst)
      diskCnt_r <= 32'h00000000;
    else if (clkEn)
    begin
      if (diskOff)
        diskCnt_r <= 32'h00000000;
      else if (diskAct)
        diskCnt_r <= 32'(DISK_CYC);
      else if (diskCnt_r != 32'h00000000)
        diskCnt_r <= diskCnt_r - 32'h00000001;
    end
  end

  // ==========================================================
  // Registered indicator outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      powerLed       <= 1'b0;
      statusGreenLed <= 1'b0;
      statusAmberLed <= 1'b0;
      diskLed        <= 1'b0;
      idFrontLed     <= 1'b0;
      idRearLed      <= 1'b0;
    end
    else if (clkEn)
    begin
      powerLed       <= (plShown == FPLBC_PL_ON) | ((plShown == FPLBC_PL_BLINK) & blink_r);
      statusGreenLed <= greenNxt & ~amberNxt;
      statusAmberLed <= amberNxt;
      diskLed        <= (diskCnt_r != 32'h00000000) & ~diskOff;
      idFrontLed     <= idOn_r;
      idRearLed      <= idOn_r;
    end
  end

  // ==========================================================
  // Button requests
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      powerToggleReq <= 1'b0;
      sleepReq       <= 1'b0;
      resetReq       <= 1'b0;
      haltReq        <= 1'b0;
      nmiReq         <= 1'b0;
    end
    else if (clkEn)
    begin
      powerToggleReq <= btnPress_r[FPLBC_BTN_PWR] & initDone & ~sleepBtnEn;
      sleepReq       <= btnPress_r[FPLBC_BTN_PWR] & initDone & sleepBtnEn;
      resetReq       <= btnPress_r[FPLBC_BTN_RST];
      haltReq        <= btnPress_r[FPLBC_BTN_NMI];
      nmiReq         <= btnPress_r[FPLBC_BTN_NMI];
    end
  end

  // ==========================================================
  // Read data, captured in the address phase
  always_comb
  begin
    statusWord                     = 32'h00000000;
    statusWord[`FPLBC_ST_PWRLED]   = powerLed;
    statusWord[`FPLBC_ST_GREEN]    = statusGreenLed;
    statusWord[`FPLBC_ST_AMBER]    = statusAmberLed;
    statusWord[`FPLBC_ST_DISK]     = diskLed;
    statusWord[`FPLBC_ST_ID]       = idOn_r;
    statusWord[`FPLBC_ST_RESTORE]  = restore_r;
    statusWord[`FPLBC_ST_DCPWR]    = dcPwr;
    statusWord[`FPLBC_ST_BLINK]    = blink_r;
    statusWord[`FPLBC_ST_BTN_LSB +: 4] = btnStable_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      hrdata_r <= 32'h00000000;
    else if (addrPhase && !hwrite)
    begin
      hrdata_r <= 32'h00000000;
      if (regHit(haddr))
      begin
        unique case (regIndex(haddr))
          2'h0: hrdata_r <= {22'h000000, ctrl_r};
          2'h1: hrdata_r <= {31'h00000000, idOn_r};
          2'h2: hrdata_r <= 32'h00000000;
          2'h3: hrdata_r <= statusWord;
        endcase
      end
    end
  end

endmodule

//--- design/fplbc_map.svh
// Register offsets, field positions, reset values and timing counts of the panel controller
`ifndef FPLBC_MAP_SVH
`define FPLBC_MAP_SVH

// ==========================================================
// Register byte offsets
`define FPLBC_OFS_CTRL      8'h00
`define FPLBC_OFS_IDENT     8'h04
`define FPLBC_OFS_FWCLR     8'h08
`define FPLBC_OFS_STATUS    8'h0c

// ==========================================================
// Control register fields
`define FPLBC_CTRL_SLP_LSB  0
`define FPLBC_CTRL_SLP_MSB  2
`define FPLBC_CTRL_ACPI     3
`define FPLBC_CTRL_SEV_LSB  4
`define FPLBC_CTRL_SEV_MSB  6
`define FPLBC_CTRL_INITDN   7
`define FPLBC_CTRL_SLPBTN   8
`define FPLBC_CTRL_ORDOFF   9
`define FPLBC_CTRL_WIDTH    10
`define FPLBC_CTRL_RESET    10'h000

// ==========================================================
// Status register fields
`define FPLBC_ST_PWRLED     0
`define FPLBC_ST_GREEN      1
`define FPLBC_ST_AMBER      2
`define FPLBC_ST_DISK       3
`define FPLBC_ST_ID         4
`define FPLBC_ST_RESTORE    5
`define FPLBC_ST_DCPWR      6
`define FPLBC_ST_BLINK      7
`define FPLBC_ST_BTN_LSB    8

// ==========================================================
// Timing
`define FPLBC_CLK_HZ        100000000
`define FPLBC_BLINK_HZ      1
`define FPLBC_BLINK_HALF    (`FPLBC_CLK_HZ / (2 * `FPLBC_BLINK_HZ))
`define FPLBC_DEB_MS        10
`define FPLBC_DEB_CYC       ((`FPLBC_CLK_HZ / 1000) * `FPLBC_DEB_MS)
`define FPLBC_DISK_MS       20
`define FPLBC_DISK_CYC      ((`FPLBC_CLK_HZ / 1000) * `FPLBC_DISK_MS)

`endif

//--- design/fplbc_pkg.sv
// Types shared by the panel controller
package fplbc_pkg;

  // ==========================================================
  // Health severity reported by the management controller
  typedef enum logic [2:0]
  {
    FPLBC_SEV_OK       = 3'h0,
    FPLBC_SEV_DEGRADED = 3'h1,
    FPLBC_SEV_NONCRIT  = 3'h2,
    FPLBC_SEV_CRIT     = 3'h3,
    FPLBC_SEV_STOP     = 3'h4
  } fplbc_sev_t;

  // ==========================================================
  // Power indicator mode, Gray coded along off, on, blink
  typedef enum logic [1:0]
  {
    FPLBC_PL_OFF   = 2'b00,
    FPLBC_PL_ON    = 2'b01,
    FPLBC_PL_BLINK = 2'b11
  } fplbc_plmode_t;

  // Button index in the button vector
  typedef enum logic [1:0]
  {
    FPLBC_BTN_PWR = 2'h0,
    FPLBC_BTN_ID  = 2'h1,
    FPLBC_BTN_RST = 2'h2,
    FPLBC_BTN_NMI = 2'h3
  } fplbc_btn_t;

endpackage

//--- tb/fplbc_platform.sv
// Behavioural model of the management controller and chipset power logic
`timescale 1ns/10ps

// ==========================================================
// Platform model
module fplbc_platform
#(
  parameter int RESP_CYC = 3
)
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic powerToggleReq,
  input  wire logic diskBusy,
  output logic      dcPowerOn,
  output logic      diskActivity
);
  int waitCnt;

  // Power good lags the request, as a real supply would
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dcPowerOn <= 1'b0;
      waitCnt   <= 0;
    end
    else if (powerToggleReq)
      waitCnt <= RESP_CYC;
    else if (waitCnt == 1)
    begin
      dcPowerOn <= ~dcPowerOn;
      waitCnt   <= 0;
    end
    else if (waitCnt != 0)
      waitCnt <= waitCnt - 1;
  end

  assign diskActivity = diskBusy;
endmodule

//--- tb/fplbc_props.sv
// Port-level assertions of the panel controller
`timescale 1ns/10ps

// ==========================================================
// Checker
module fplbc_props
(
  input wire logic clk,
  input wire logic srst,
  input wire logic pwrBtn_n,
  input wire logic rstBtn_n,
  input wire logic nmiBtn_n,
  input wire logic dcPowerOn,
  input wire logic statusGreenLed,
  input wire logic statusAmberLed,
  input wire logic diskLed,
  input wire logic idFrontLed,
  input wire logic idRearLed,
  input wire logic powerToggleReq,
  input wire logic sleepReq,
  input wire logic resetReq,
  input wire logic haltReq,
  input wire logic nmiReq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Sync and output flop take three cycles, so four low samples suffice
  sequence s_dark;
    !dcPowerOn [*4];
  endsequence

  sequence s_rst_pulse;
    resetReq ##1 !resetReq;
  endsequence

  a_amber_masks_green: assert property (statusAmberLed |-> !statusGreenLed)
    else $error("green lit with amber");
  a_id_pair_match: assert property (idFrontLed == idRearLed)
    else $error("front and rear identify differ");
  a_halt_nmi_pair: assert property (haltReq == nmiReq)
    else $error("halt and nmi requests apart");
  a_reset_one_pulse: assert property (resetReq |-> s_rst_pulse)
    else $error("reset request longer than one cycle");
  a_pwr_req_excl: assert property (!(powerToggleReq && sleepReq))
    else $error("power and sleep requests together");
  a_reset_cause: assert property (resetReq |-> $past(rstBtn_n, 3) == 1'b0)
    else $error("reset request without press");
  a_nmi_cause: assert property (nmiReq |-> $past(nmiBtn_n, 3) == 1'b0)
    else $error("nmi request without press");
  a_pwr_cause: assert property ((powerToggleReq || sleepReq) |-> $past(pwrBtn_n, 3) == 1'b0)
    else $error("power request without press");
  a_disk_dark: assert property (s_dark |-> !diskLed)
    else $error("disk led lit while unpowered");
endmodule

bind fplbc_ctrl fplbc_props uProps (
  .clk(clk), .srst(srst), .pwrBtn_n(pwrBtn_n), .rstBtn_n(rstBtn_n), .nmiBtn_n(nmiBtn_n),
  .dcPowerOn(dcPowerOn), .statusGreenLed(statusGreenLed), .statusAmberLed(statusAmberLed),
  .diskLed(diskLed), .idFrontLed(idFrontLed), .idRearLed(idRearLed),
  .powerToggleReq(powerToggleReq), .sleepReq(sleepReq), .resetReq(resetReq),
  .haltReq(haltReq), .nmiReq(nmiReq));

//--- tb/tb_front_panel_led_button_ctrl.sv
// Self-checking bench of the panel controller
`timescale 1ns/10ps

// ==========================================================
// Bench
module tb_front_panel_led_button_ctrl
  import fplbc_pkg::*;
;
  logic        clk = 1'b0, srst = 1'b1, clkEn = 1'b1, hsel = 1'b0;
  logic        hwrite = 1'b0, diskBusy = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  btnN = 4'hf;
  logic [31:0] hrdata;
  logic        hready, hreadyout, hresp, dcPowerOn, diskActivity;
  logic        powerLed, statusGreenLed, statusAmberLed, diskLed, idFrontLed, idRearLed;
  logic        powerToggleReq, sleepReq, resetReq, haltReq, nmiReq;
  logic [4:0]  leds, reqs;
  int          nFail = 0, testsRun = 0, cyc = 0;
  int          pc[5];

  assign hready = hreadyout;
  assign leds   = {idFrontLed, diskLed, statusAmberLed, statusGreenLed, powerLed};
  assign reqs   = {nmiReq, haltReq, resetReq, sleepReq, powerToggleReq};

  always #5 clk = ~clk;

  fplbc_ctrl #(.BLINK_HALF_CYC(8), .DEB_CYC(4), .DISK_CYC(4)) DUT (
    .clk(clk), .srst(srst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwrBtn_n(btnN[0]),
    .idBtn_n(btnN[1]), .rstBtn_n(btnN[2]), .nmiBtn_n(btnN[3]), .dcPowerOn(dcPowerOn),
    .diskActivity(diskActivity), .powerLed(powerLed), .statusGreenLed(statusGreenLed),
    .statusAmberLed(statusAmberLed), .diskLed(diskLed), .idFrontLed(idFrontLed),
    .idRearLed(idRearLed), .powerToggleReq(powerToggleReq), .sleepReq(sleepReq),
    .resetReq(resetReq), .haltReq(haltReq), .nmiReq(nmiReq));

  fplbc_platform #(.RESP_CYC(3)) uPlat (
    .clk(clk), .srst(srst), .powerToggleReq(powerToggleReq), .diskBusy(diskBusy),
    .dcPowerOn(dcPowerOn), .diskActivity(diskActivity));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // Sixteen cycles span one whole blink period, so phase does not matter
  task automatic meas(input int i, input logic [31:0] e);
    logic [31:0] n;
    n = 32'h0;
    repeat (6) @(posedge clk);
    repeat (16)
    begin
      @(posedge clk);
      n += leds[i];
    end
    chk(n, e, "led on-cycles");
  endtask

  task automatic press(input fplbc_btn_t b);
    foreach (pc[j]) pc[j] = 0;
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk);
      btnN[b] <= (k >= 20);
      foreach (pc[j]) pc[j] += reqs[j];
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_init();
    meas(1, 32'h8);
    meas(2, 32'h8);
    press(FPLBC_BTN_PWR);
    chk(pc[0], 32'h0, "power press during init");
    $display("test init done");
  endtask

  task automatic t_btn();
    fplbc_btn_t  bt[5] = '{FPLBC_BTN_PWR, FPLBC_BTN_PWR, FPLBC_BTN_RST, FPLBC_BTN_NMI,
                           FPLBC_BTN_ID};
    logic [31:0] cv[5] = '{32'h80, 32'h180, 32'h80, 32'h80, 32'h80};
    logic [4:0]  em[5] = '{5'h01, 5'h02, 5'h04, 5'h18, 5'h00};
    logic [31:0] r;
    for (int k = 0; k < 5; k++)
    begin
      wr(32'h0, cv[k]);
      press(bt[k]);
      for (int j = 0; j < 5; j++)
        chk(pc[j], em[k][j], "request pulses");
    end
    chk(idFrontLed, 1'b1, "identify on by press");
    press(FPLBC_BTN_ID);
    chk(idRearLed, 1'b0, "identify off by press");
    wr(32'h4, 32'h1);
    bus(1'b0, 32'hc, 32'h0, r);
    chk(r[4], 1'b1, "identify on by command");
    chk(idFrontLed, 1'b1, "identify led by command");
    bus(1'b0, 32'h10, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    chk({hreadyout, hresp}, 32'h2, "bus ready and okay");
    $display("test buttons done");
  endtask

  task automatic t_status();
    logic [31:0] eg[5] = '{32'h10, 32'h8, 32'h0, 32'h0, 32'h0};
    logic [31:0] ea[5] = '{32'h0, 32'h0, 32'h8, 32'h10, 32'h0};
    for (int s = 0; s < 5; s++)
    begin
      wr(32'h0, 32'h88 | (s << 4));
      meas(1, eg[s]);
      meas(2, ea[s]);
    end
    $display("test status done");
  endtask

  task automatic t_power();
    logic [31:0] ep[6] = '{32'h10, 32'h8, 32'h8, 32'h8, 32'h0, 32'h0};
    for (int s = 0; s < 6; s++)
    begin
      wr(32'h0, 32'h88 | s);
      meas(0, ep[s]);
    end
    wr(32'h0, 32'h80);
    meas(0, 32'h10);
    $display("test power led done");
  endtask

  task automatic t_disk();
    logic [31:0] n;
    for (int s = 0; s < 2; s++)
    begin
      wr(32'h0, 32'h88 | s);
      @(posedge clk);
      diskBusy <= 1'b1;
      @(posedge clk);
      diskBusy <= 1'b0;
      n = 32'h0;
      repeat (16)
      begin
        @(posedge clk);
        n += diskLed;
      end
      chk(n != 0, s == 0, "disk flash");
    end
    $display("test disk done");
  endtask

  task automatic t_restore();
    wr(32'h0, 32'h89);
    press(FPLBC_BTN_PWR);
    meas(0, 32'h0);
    wr(32'h0, 32'h88);
    press(FPLBC_BTN_PWR);
    meas(0, 32'h8);
    wr(32'h8, 32'h1);
    meas(0, 32'h10);
    $display("test restore done");
  endtask

  // ==========================================================
  // Run control
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs about 1000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      nFail++;
      $display("MISMATCH t=%0t run timed out", $time);
      closeOut();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_init();
    t_btn();
    t_status();
    t_power();
    t_disk();
    t_restore();
    closeOut();
  end
endmodule
